// *** include/sw_ils_pkg.sv ***
// Package for the switch link service engine: header codes, command
// codes, reject reason codes, delimiter codes and engine states.
// Assumes frames are parsed and framed by surrounding port logic.
package sw_ils_pkg;

  // ----------------------------------------------------------------------
  // Frame header field values
  // ----------------------------------------------------------------------
  localparam logic [7:0] RCTL_REQUEST = 8'h02;
  localparam logic [7:0] RCTL_REPLY = 8'h03;
  localparam logic [7:0] CSCTL_ZERO = 8'h00;
  localparam logic [7:0] TYPE_SW_SVC = 8'h22;
  localparam logic [23:0] FABRIC_CTRL_ID = 24'hFF_FFFD;
  localparam logic [1:0] FRAME_FMT_FT1 = 2'h1;

  // ----------------------------------------------------------------------
  // Delimiter and link control codes
  // ----------------------------------------------------------------------
  localparam logic [1:0] SOF_CODE_F = 2'h1;
  localparam logic [1:0] EOF_CODE_N = 2'h1;
  localparam logic [1:0] EOF_CODE_T = 2'h2;
  localparam logic [1:0] ACK_KIND_1 = 2'h1;

  // ----------------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------------
  localparam logic [31:0] CMD_REJECT = 32'h0100_0000;
  localparam logic [31:0] CMD_ACCEPT = 32'h0200_0000;
  localparam logic [31:0] CMD_LINK_PARAM = 32'h1000_0000;
  localparam logic [31:0] CMD_SVC_FIRST = 32'h1100_0000;
  localparam logic [31:0] CMD_SVC_LAST = 32'h1800_0000;
  localparam logic [31:0] CMD_DISCONNECT = 32'h2000_0000;
  localparam logic [31:0] CMD_DEADLOCK = 32'h2100_0000;
  localparam logic [31:0] CMD_VENDOR_FIRST = 32'h7000_0000;
  localparam logic [31:0] CMD_VENDOR_LAST = 32'h7F00_0000;
  localparam logic [31:0] CMD_LOW_MASK = 32'h00FF_FFFF;

  // ----------------------------------------------------------------------
  // Reject reason word layout and codes
  // ----------------------------------------------------------------------
  localparam int RSN_CODE_LSB = 16;
  localparam int RSN_EXPL_LSB = 8;
  localparam logic [7:0] RSN_INVALID_CMD = 8'h01;
  localparam logic [7:0] RSN_BAD_REV = 8'h02;
  localparam logic [7:0] RSN_LOGICAL = 8'h03;
  localparam logic [7:0] RSN_BAD_SIZE = 8'h04;
  localparam logic [7:0] RSN_BUSY = 8'h05;
  localparam logic [7:0] RSN_PROTOCOL = 8'h07;
  localparam logic [7:0] RSN_UNABLE = 8'h09;
  localparam logic [7:0] RSN_NOT_SUPP = 8'h0B;
  localparam logic [7:0] RSN_VENDOR = 8'hFF;
  localparam logic [7:0] EXPL_NONE = 8'h00;
  localparam logic [7:0] EXPL_CLASS_F = 8'h01;
  localparam logic [7:0] EXPL_TOV = 8'h0F;
  localparam logic [7:0] EXPL_DOMAIN = 8'h2A;
  localparam logic [7:0] EXPL_NOT_SUPP = 8'h2C;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // ----------------------------------------------------------------------
  // Payload sizes in bytes
  // ----------------------------------------------------------------------
  localparam logic [15:0] LEN_CMD_ONLY = 16'h0004;
  localparam logic [15:0] LEN_REJECT = 16'h0008;
  localparam logic [15:0] LEN_LINK_PARAM_MIN = 16'h0054;

  // ----------------------------------------------------------------------
  // Engine states
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_TERM = 3'b010,
    ST_SEND = 3'b100
  } eng_state_t;

endpackage

// *** logic/ils_cmd_classifier.sv ***
// Command word classifier for internal link service frames.
// Assumes a whole 32-bit first payload word on its input.
`timescale 1ns/10ps
`default_nettype none
module ils_cmd_classifier
  import sw_ils_pkg::*;
(
  input wire logic [31:0] cmd_word,
  output logic known,
  output logic is_link_param,
  output logic is_vendor,
  output logic is_reply
);

  logic low_zero;

  // --------------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------------
  always_comb begin
    low_zero = ((cmd_word & CMD_LOW_MASK) == 32'h0000_0000);
    is_link_param = (cmd_word == CMD_LINK_PARAM);
    is_reply = (cmd_word == CMD_REJECT) || (cmd_word == CMD_ACCEPT);
    is_vendor = low_zero && (cmd_word >= CMD_VENDOR_FIRST)
      && (cmd_word <= CMD_VENDOR_LAST);
    known = is_link_param || is_reply || is_vendor
      || (cmd_word == CMD_DISCONNECT) || (cmd_word == CMD_DEADLOCK)
      || (low_zero && (cmd_word >= CMD_SVC_FIRST) && (cmd_word <= CMD_SVC_LAST));
  end

endmodule // ils_cmd_classifier
`default_nettype wire

// *** logic/switch_link_service_engine.sv ***
// Switch link service engine: credit return, Class F acknowledgements,
// service request decode and accept or reject reply generation.
// Assumes frame parsing, CRC and delimiter coding live in the port logic.
//
// Notes on behaviour
// - Freed receive buffer sends one R_RDY
// - Acknowledgements are ACK_1 starting with SOFf
// - ACK_1 ends with EOFn or EOFt only
// - Never produce ACK_0 or ACK_N
// - Service frames are Class F, FT-1 format
// - Routing control 02 request, 03 reply
// - Frame type field is hex 22
// - First payload word is the command code
// - Accept, reject, exchange and service codes
// - Disconnect, deadlock, vendor unique; others reserved
// - Any request may be rejected
// - Reject swaps source and destination identifiers
// - Reject payload: command word, reason word
// - Reason code sits in bits 23..16
// - Unrecognised command gives reason 01
// - Busy gives reason 05
// - Bad payload length gives reason 04
// - Explanation sits in bits 15..8
// - Vendor byte only meaningful for vendor reason
// - Exchange request aborts sequences before accept
// - Exactly one reply per exchange request
// - Exchange uses fabric controller identifiers; the engine neither checks nor sets them, it swaps the request identifiers
// - Credit of one until parameters exchanged
`timescale 1ns/10ps
`default_nettype none
module switch_link_service_engine
  import sw_ils_pkg::*;
#(
  parameter int CREDIT_W = 8
)
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic buf_freed,
  output logic r_rdy_send,
  input wire logic r_rdy_rcvd,
  input wire logic tx_frame_sent,
  input wire logic params_done,
  input wire logic [CREDIT_W-1:0] bb_credit,
  output logic tx_credit_ok,
  input wire logic data_rcvd,
  input wire logic data_last,
  input wire logic [23:0] data_s_id,
  input wire logic [23:0] data_d_id,
  output logic ack_valid,
  input wire logic ack_ready,
  output logic [1:0] ack_kind,
  output logic [1:0] ack_sof,
  output logic [1:0] ack_eof,
  output logic [23:0] ack_s_id,
  output logic [23:0] ack_d_id,
  input wire logic rx_valid,
  output logic rx_ready,
  input wire logic rx_sof_f,
  input wire logic [7:0] rx_r_ctl,
  input wire logic [7:0] rx_type,
  input wire logic [23:0] rx_s_id,
  input wire logic [23:0] rx_d_id,
  input wire logic [15:0] rx_len,
  input wire logic [31:0] rx_cmd,
  input wire logic busy,
  input wire logic force_reject,
  output logic svc_req,
  output logic [31:0] svc_cmd,
  output logic reply_rcvd,
  output logic term_req,
  input wire logic term_done,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [1:0] tx_sof,
  output logic [1:0] tx_fmt,
  output logic [7:0] tx_r_ctl,
  output logic [7:0] tx_cs_ctl,
  output logic [7:0] tx_type,
  output logic [23:0] tx_s_id,
  output logic [23:0] tx_d_id,
  output logic [31:0] tx_word0,
  output logic [31:0] tx_word1,
  output logic [15:0] tx_len
);

  function automatic logic [31:0] reason_word(input logic [7:0] code, input logic [7:0] expl);
    reason_word = {BYTE_ZERO, code, expl, BYTE_ZERO};
  endfunction

  // --------------------------------------------------------------------
  // Buffer credit
  // --------------------------------------------------------------------
  logic r_rdy_q, r_rdy_d;
  logic [CREDIT_W-1:0] out_q, out_d, limit;

  always_comb begin
    r_rdy_d = buf_freed;
    limit = params_done ? bb_credit : CREDIT_W'(1);
    out_d = out_q;
    if (tx_frame_sent && !r_rdy_rcvd) begin
      out_d = out_q + CREDIT_W'(1);
    end else if (r_rdy_rcvd && !tx_frame_sent && out_q != '0) begin
      out_d = out_q - CREDIT_W'(1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      r_rdy_q <= 1'b0;
      out_q <= '0;
    end else begin
      r_rdy_q <= r_rdy_d;
      out_q <= out_d;
    end
  end

  assign r_rdy_send = r_rdy_q;
  assign tx_credit_ok = (out_q < limit);

  // --------------------------------------------------------------------
  // Acknowledgements
  // --------------------------------------------------------------------
  logic ack_v_q, ack_v_d, ack_last_q, ack_last_d;
  logic [23:0] ack_s_q, ack_s_d, ack_d_q, ack_d_d;

  always_comb begin
    ack_v_d = ack_v_q;
    ack_last_d = ack_last_q;
    ack_s_d = ack_s_q;
    ack_d_d = ack_d_q;
    if (ack_v_q && ack_ready) begin
      ack_v_d = 1'b0;
    end
    if (data_rcvd && (!ack_v_q || ack_ready)) begin
      ack_v_d = 1'b1;
      ack_last_d = data_last;
      ack_s_d = data_d_id;
      ack_d_d = data_s_id;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      ack_v_q <= 1'b0;
      ack_last_q <= 1'b0;
      ack_s_q <= '0;
      ack_d_q <= '0;
    end else begin
      ack_v_q <= ack_v_d;
      ack_last_q <= ack_last_d;
      ack_s_q <= ack_s_d;
      ack_d_q <= ack_d_d;
    end
  end

  assign ack_valid = ack_v_q;
  assign ack_kind = ACK_KIND_1;
  assign ack_sof = SOF_CODE_F;
  assign ack_eof = ack_last_q ? EOF_CODE_T : EOF_CODE_N;
  assign ack_s_id = ack_s_q;
  assign ack_d_id = ack_d_q;

  // --------------------------------------------------------------------
  // Request decode and reply
  // --------------------------------------------------------------------
  logic c_known, c_link, c_vendor, c_reply;
  eng_state_t st_q, st_d;
  logic [23:0] rs_q, rs_d, rd_q, rd_d;
  logic [31:0] w0_q, w0_d, w1_q, w1_d, svc_q, svc_d;
  logic [15:0] len_q, len_d;
  logic svc_req_q, svc_req_d, rep_q, rep_d, term_q, term_d;
  logic take, is_ils, len_bad;

  ils_cmd_classifier u_class (
    .cmd_word(rx_cmd),
    .known(c_known),
    .is_link_param(c_link),
    .is_vendor(c_vendor),
    .is_reply(c_reply)
  );

  always_comb begin
    rx_ready = (st_q == ST_IDLE);
    take = rx_valid && rx_ready;
    is_ils = rx_sof_f && (rx_type == TYPE_SW_SVC);
    len_bad = (rx_len < LEN_CMD_ONLY) || (rx_len[1:0] != 2'b00)
      || (c_link && rx_len < LEN_LINK_PARAM_MIN);
    st_d = st_q;
    rs_d = rs_q;
    rd_d = rd_q;
    w0_d = w0_q;
    w1_d = w1_q;
    len_d = len_q;
    svc_d = svc_q;
    svc_req_d = 1'b0;
    rep_d = 1'b0;
    term_d = 1'b0;
    case (st_q)
      ST_IDLE: begin
        if (take && is_ils && rx_r_ctl == RCTL_REPLY && c_reply) begin
          rep_d = 1'b1;
        end else if (take && is_ils && rx_r_ctl == RCTL_REQUEST) begin
          rs_d = rx_d_id;
          rd_d = rx_s_id;
          w0_d = CMD_REJECT;
          len_d = LEN_REJECT;
          st_d = ST_SEND;
          if (!c_known || c_reply) begin
            w1_d = reason_word(RSN_INVALID_CMD, EXPL_NONE);
          end else if (busy) begin
            w1_d = reason_word(RSN_BUSY, EXPL_NONE);
          end else if (len_bad) begin
            w1_d = reason_word(RSN_BAD_SIZE, EXPL_NONE);
          end else if (c_vendor) begin
            w1_d = reason_word(RSN_NOT_SUPP, EXPL_NOT_SUPP);
          end else if (force_reject) begin
            w1_d = reason_word(RSN_UNABLE, EXPL_NONE);
          end else begin
            w0_d = CMD_ACCEPT;
            w1_d = '0;
            len_d = LEN_CMD_ONLY;
            if (c_link) begin
              term_d = 1'b1;
              st_d = ST_TERM;
            end else begin
              svc_req_d = 1'b1;
              svc_d = rx_cmd;
            end
          end
        end
      end
      ST_TERM: begin
        if (term_done) begin
          st_d = ST_SEND;
        end
      end
      ST_SEND: begin
        if (tx_ready) begin
          st_d = ST_IDLE;
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      st_q <= ST_IDLE;
      rs_q <= '0;
      rd_q <= '0;
      w0_q <= '0;
      w1_q <= '0;
      len_q <= '0;
      svc_q <= '0;
      svc_req_q <= 1'b0;
      rep_q <= 1'b0;
      term_q <= 1'b0;
    end else begin
      st_q <= st_d;
      rs_q <= rs_d;
      rd_q <= rd_d;
      w0_q <= w0_d;
      w1_q <= w1_d;
      len_q <= len_d;
      svc_q <= svc_d;
      svc_req_q <= svc_req_d;
      rep_q <= rep_d;
      term_q <= term_d;
    end
  end

  assign svc_req = svc_req_q;
  assign svc_cmd = svc_q;
  assign reply_rcvd = rep_q;
  assign term_req = term_q;
  assign tx_valid = (st_q == ST_SEND);
  assign tx_sof = SOF_CODE_F;
  assign tx_fmt = FRAME_FMT_FT1;
  assign tx_r_ctl = RCTL_REPLY;
  assign tx_cs_ctl = CSCTL_ZERO;
  assign tx_type = TYPE_SW_SVC;
  assign tx_s_id = rs_q;
  assign tx_d_id = rd_q;
  assign tx_word0 = w0_q;
  assign tx_word1 = w1_q;
  assign tx_len = len_q;

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  a_rrdy_return: assert property (
    @(posedge sys_clk) disable iff (!resetn) buf_freed |=> r_rdy_send)
    else $error("freed buffer gave no credit return");

  a_ack_delims: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (data_rcvd && !ack_valid && data_last) |=> ack_valid && ack_sof == SOF_CODE_F
      && ack_eof == EOF_CODE_T && ack_kind == ACK_KIND_1 && ack_d_id == $past(data_s_id))
    else $error("acknowledgement framed wrongly");

  a_reply_header: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    tx_valid |-> tx_r_ctl == 8'h03 && tx_cs_ctl == 8'h00 && tx_type == 8'h22)
    else $error("reply header fields wrong");

  a_reject_invalid: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (take && is_ils && rx_r_ctl == RCTL_REQUEST && !c_known)
      |=> tx_valid && tx_s_id == $past(rx_d_id) && tx_d_id == $past(rx_s_id)
      && tx_word0 == 32'h0100_0000 && tx_word1[23:16] == 8'h01)
    else $error("unrecognised command not rejected properly");

  a_busy_reason: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (take && is_ils && rx_r_ctl == RCTL_REQUEST && c_known && !c_reply && busy)
      |=> tx_word1 == 32'h0005_0000)
    else $error("busy reason wrong");

  a_size_reason: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (take && is_ils && rx_r_ctl == RCTL_REQUEST && c_link && !busy && rx_len < 16'h0054)
      |=> tx_word1[23:16] == 8'h04)
    else $error("short exchange not rejected for size");

  a_term_before: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (!tx_valid && !rx_ready && !term_done) |=> !tx_valid)
    else $error("accept sent before termination");

  a_one_reply: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (tx_valid && tx_ready) |=> !tx_valid ##1 (!tx_valid || $past(rx_valid && rx_ready)))
    else $error("more than one reply sent");

  a_credit_one: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (!params_done && out_q != '0) |-> !tx_credit_ok)
    else $error("credit above one before exchange");

endmodule // switch_link_service_engine
`default_nettype wire

// *** sim/ils_peer_model.sv ***
// Far-side model: peer port taking replies and acks, and the local
// abort helper answering term_req a few cycles later.
// Assumes stall_mode from the bench picks steady or random ready lines; term_done timing is fixed.
`timescale 1ns/10ps
`default_nettype none
module ils_peer_model (
  input wire logic sys_clk,
  input wire logic stall_mode,
  input wire logic term_req,
  output logic tx_ready,
  output logic ack_ready,
  output logic term_done
);
  logic [2:0] cnt_q;
  initial begin
    tx_ready = 1'h0;
    ack_ready = 1'h0;
    term_done = 1'h0;
    cnt_q = 3'h0;
  end
  // --------------------------------------------------------------
  // Ready lines and abort answer
  // --------------------------------------------------------------
  always @(posedge sys_clk) begin
    tx_ready <= stall_mode ? 1'($urandom_range(0, 1)) : 1'h1;
    ack_ready <= stall_mode ? 1'($urandom_range(0, 1)) : 1'h1;
    term_done <= (cnt_q == 3'h1);
    if (term_req)
      cnt_q <= 3'h4;
    else if (cnt_q != 3'h0)
      cnt_q <= cnt_q - 3'h1;
  end
endmodule // ils_peer_model
`default_nettype wire

// *** sim/test_switch_link_service_engine.sv ***
// Testbench: credit return, acks, service requests and replies.
// Assumes the peer model supplies tx_ready, ack_ready, term_done.
`timescale 1ns/10ps
`default_nettype none
module test_switch_link_service_engine
  import sw_ils_pkg::*;
();
  logic sys_clk, resetn, buf_freed, r_rdy_send, r_rdy_rcvd, tx_frame_sent;
  logic params_done, tx_credit_ok, data_rcvd, data_last, ack_valid, ack_ready;
  logic [7:0] bb_credit, rx_r_ctl, rx_type, tx_r_ctl, tx_cs_ctl, tx_type;
  logic [23:0] data_s_id, data_d_id, ack_s_id, ack_d_id, rx_s_id, rx_d_id;
  logic [23:0] tx_s_id, tx_d_id;
  logic [1:0] ack_kind, ack_sof, ack_eof, tx_sof, tx_fmt;
  logic rx_valid, rx_ready, rx_sof_f, busy, force_reject, svc_req;
  logic reply_rcvd, term_req, term_done, tx_valid, tx_ready, stall;
  logic [15:0] rx_len, tx_len;
  logic [31:0] rx_cmd, svc_cmd, tx_word0, tx_word1;
  int n_errors = 0;
  int n_compared = 0;
  logic [31:0] cl[$];
  switch_link_service_engine #(.CREDIT_W(8)) dut (.sys_clk, .resetn,
    .buf_freed, .r_rdy_send, .r_rdy_rcvd, .tx_frame_sent, .params_done,
    .bb_credit, .tx_credit_ok, .data_rcvd, .data_last, .data_s_id,
    .data_d_id, .ack_valid, .ack_ready, .ack_kind, .ack_sof, .ack_eof,
    .ack_s_id, .ack_d_id, .rx_valid, .rx_ready, .rx_sof_f, .rx_r_ctl,
    .rx_type, .rx_s_id, .rx_d_id, .rx_len, .rx_cmd, .busy, .force_reject,
    .svc_req, .svc_cmd, .reply_rcvd, .term_req, .term_done, .tx_valid,
    .tx_ready, .tx_sof, .tx_fmt, .tx_r_ctl, .tx_cs_ctl, .tx_type, .tx_s_id,
    .tx_d_id, .tx_word0, .tx_word1, .tx_len);
  ils_peer_model peer (.sys_clk, .stall_mode(stall), .term_req, .tx_ready,
    .ack_ready, .term_done);
  initial begin
    sys_clk = 1'h0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // --------------------------------------------------------------
  // Compare, wait and verdict
  // --------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic give_verdict();
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wait_hs(input int k);
    for (int i = 0; i < 200; i++) begin
      if (k == 0 && tx_valid === 1'h1 && tx_ready === 1'h1) return;
      if (k == 1 && ack_valid === 1'h1 && ack_ready === 1'h1) return;
      if (k == 2 && rx_ready === 1'h1) return;
      @(negedge sys_clk);
    end
    n_errors++;
    give_verdict();
  endtask
  task automatic pulse(input int k);
    @(negedge sys_clk);
    buf_freed = (k == 0);
    tx_frame_sent = (k == 1);
    r_rdy_rcvd = (k == 2);
    @(negedge sys_clk);
    {buf_freed, tx_frame_sent, r_rdy_rcvd} = 3'h0;
  endtask
  // --------------------------------------------------------------
  // Expected reason word
  // --------------------------------------------------------------
  function automatic logic [31:0] rw(logic [7:0] r, logic [7:0] x);
    return {BYTE_ZERO, r, x, BYTE_ZERO};
  endfunction
  function automatic logic [31:0] exp_w1(logic [31:0] c, logic [15:0] l,
                                         logic bz, logic fr);
    logic kn;
    kn = (c & CMD_LOW_MASK) == 32'h0000_0000 && ((c >= CMD_LINK_PARAM &&
      c <= CMD_SVC_LAST) || c == CMD_DISCONNECT || c == CMD_DEADLOCK ||
      (c >= CMD_VENDOR_FIRST && c <= CMD_VENDOR_LAST));
    if (!kn) return rw(RSN_INVALID_CMD, EXPL_NONE);
    if (bz) return rw(RSN_BUSY, EXPL_NONE);
    if (l < 16'h0004 || l[1:0] != 2'h0 || (c == CMD_LINK_PARAM && l < 16'h0054))
      return rw(RSN_BAD_SIZE, EXPL_NONE);
    if (c >= CMD_VENDOR_FIRST) return rw(RSN_NOT_SUPP, EXPL_NOT_SUPP);
    if (fr) return rw(RSN_UNABLE, EXPL_NONE);
    return 32'h0000_0000;
  endfunction
  // --------------------------------------------------------------
  // Frame drivers
  // --------------------------------------------------------------
  task automatic ack(input logic last);
    logic [23:0] s, d;
    s = 24'($urandom);
    d = 24'($urandom);
    {data_rcvd, data_last, data_s_id, data_d_id} = {1'h1, last, s, d};
    @(negedge sys_clk);
    {data_rcvd, data_s_id, data_d_id} = {1'h0, ~s, ~d};
    wait_hs(1);
    chk("ack_kind", ACK_KIND_1, ack_kind);
    chk("ack_sof", SOF_CODE_F, ack_sof);
    chk("ack_eof", last ? EOF_CODE_T : EOF_CODE_N, ack_eof);
    chk("ack_s_id", d, ack_s_id);
    chk("ack_d_id", s, ack_d_id);
    @(negedge sys_clk);
    chk("ack_valid", 1'h0, ack_valid);
  endtask
  task automatic req(input logic [31:0] c, input logic [15:0] l, input logic bz,
                     input logic fr, input logic [7:0] rc, input logic [7:0] ty);
    logic [31:0] w1;
    logic [23:0] s, d;
    logic act;
    w1 = exp_w1(c, l, bz, fr);
    s = (c == CMD_LINK_PARAM) ? FABRIC_CTRL_ID : 24'($urandom);
    d = (c == CMD_LINK_PARAM) ? FABRIC_CTRL_ID : 24'($urandom);
    act = (rc == RCTL_REQUEST && ty == TYPE_SW_SVC);
    wait_hs(2);
    {rx_valid, rx_sof_f, rx_r_ctl, rx_type} = {1'h1, 1'h1, rc, ty};
    {rx_s_id, rx_d_id, rx_len, rx_cmd, busy, force_reject} = {s, d, l, c, bz, fr};
    @(negedge sys_clk);
    {rx_valid, rx_cmd, rx_s_id, rx_d_id} = {1'h0, ~c, ~s, ~d};
    chk("reply_rcvd", rc == RCTL_REPLY && ty == TYPE_SW_SVC, reply_rcvd);
    chk("svc_req", act && w1 == 0 && c != CMD_LINK_PARAM, svc_req);
    chk("term_req", act && w1 == 0 && c == CMD_LINK_PARAM, term_req);
    if (!act) begin
      repeat (3) @(negedge sys_clk);
      chk("tx_valid", 1'h0, tx_valid);
      return;
    end
    if (svc_req === 1'h1) chk("svc_cmd", c, svc_cmd);
    if (term_req === 1'h1) begin
      @(negedge sys_clk);
      chk("tx_valid", 1'h0, tx_valid);
    end
    wait_hs(0);
    chk("tx_word0", w1 == 0 ? CMD_ACCEPT : CMD_REJECT, tx_word0);
    chk("tx_word1", w1, tx_word1);
    chk("tx_len", w1 == 0 ? LEN_CMD_ONLY : LEN_REJECT, tx_len);
    chk("tx_ids", {s, d}, {tx_d_id, tx_s_id});
    chk("tx_hdr", {RCTL_REPLY, CSCTL_ZERO, TYPE_SW_SVC}, {tx_r_ctl, tx_cs_ctl, tx_type});
    chk("tx_fmt", {SOF_CODE_F, FRAME_FMT_FT1}, {tx_sof, tx_fmt});
    @(negedge sys_clk);
    chk("tx_valid", 1'h0, tx_valid);
  endtask
  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    {resetn, buf_freed, r_rdy_rcvd, tx_frame_sent, params_done, stall} = 6'h00;
    {bb_credit, data_rcvd, data_last, data_s_id, data_d_id} = '0;
    {rx_valid, rx_sof_f, rx_r_ctl, rx_type, rx_s_id, rx_d_id} = '0;
    {rx_len, rx_cmd, busy, force_reject} = '0;
    void'($urandom(46309));
    repeat (6) @(negedge sys_clk);
    resetn = 1'h1;
    chk("rst", 2'h3, {tx_credit_ok, rx_ready});
    pulse(0);
    chk("r_rdy_send", 1'h1, r_rdy_send);
    @(negedge sys_clk);
    chk("r_rdy_send", 1'h0, r_rdy_send);
    pulse(1);
    chk("credit_ok", 1'h0, tx_credit_ok);
    pulse(2);
    chk("credit_ok", 1'h1, tx_credit_ok);
    {params_done, bb_credit} = {1'h1, 8'h02};
    pulse(1);
    chk("credit_ok", 1'h1, tx_credit_ok);
    pulse(1);
    chk("credit_ok", 1'h0, tx_credit_ok);
    pulse(2);
    chk("credit_ok", 1'h1, tx_credit_ok);
    for (int i = 0; i < 16; i++) begin
      stall = (i >= 8);
      ack(1'($urandom_range(0, 1)));
    end
    cl = {CMD_LINK_PARAM, CMD_DISCONNECT, CMD_DEADLOCK, CMD_REJECT, CMD_ACCEPT,
      CMD_VENDOR_FIRST, CMD_VENDOR_LAST, 32'h1100_0001, 32'h6F00_0000};
    for (logic [31:0] c = CMD_SVC_FIRST; c <= CMD_SVC_LAST; c += 32'h0100_0000)
      cl.push_back(c);
    foreach (cl[i]) req(cl[i], cl[i] == CMD_LINK_PARAM ? 16'h0054 : 16'h0004,
      1'h0, 1'h0, RCTL_REQUEST, TYPE_SW_SVC);
    req(CMD_LINK_PARAM, 16'h0050, 1'h0, 1'h0, RCTL_REQUEST, TYPE_SW_SVC);
    req(CMD_SVC_FIRST, 16'h0006, 1'h0, 1'h0, RCTL_REQUEST, TYPE_SW_SVC);
    req(CMD_ACCEPT, 16'h0004, 1'h0, 1'h0, RCTL_REPLY, TYPE_SW_SVC);
    req(CMD_SVC_FIRST, 16'h0004, 1'h0, 1'h0, RCTL_REQUEST, 8'h20);
    for (int i = 0; i < 40; i++) begin
      stall = 1'($urandom_range(0, 1));
      req($urandom_range(0, 3) == 0 ? {8'($urandom_range(8'h30, 8'h6F)), 24'h00_0000}
        : cl[$urandom_range(0, cl.size() - 1)], 16'($urandom_range(0, 25) * 4 + 2 *
        ($urandom_range(0, 5) == 0)), $urandom_range(0, 6) == 0,
        $urandom_range(0, 6) == 0, RCTL_REQUEST, TYPE_SW_SVC);
    end
    give_verdict();
  end
endmodule // test_switch_link_service_engine
`default_nettype wire
